/* File: shared/nv_config_defines.svh */
// constants for the configuration word map and the fault duty logic
// assumes word indices on the bus, byte address = index * 4
`ifndef NV_CONFIG_DEFINES_SVH
`define NV_CONFIG_DEFINES_SVH

// word indices
`define IDX_PWM_FAULT_ENABLE   8'h18
`define IDX_QUAD_OUTPUT_CTRL   8'h19
`define IDX_FAULT_FLAG_MASK    8'h1a
`define IDX_PWM_INTERFACE_CTRL 8'h1b
`define IDX_POSITION_CONFIG    8'h1c
`define IDX_TURNS_CONFIG       8'h1d
`define IDX_GENERAL_CONFIG     8'h1e
`define IDX_USER_NV_SPACE      8'h1f
`define IDX_NV_FIRST           8'h18
`define IDX_NV_LAST            8'h1f
`define IDX_SHADOW_FIRST       8'h58
`define IDX_SHADOW_LAST        8'h5e
`define IDX_UNLOCK_KEY         8'h3c
`define IDX_IRQ_STATUS         8'h40
`define IDX_IRQ_MASK           8'h41
`define IDX_FAULT_LIVE         8'h42

// word layout
`define NV_WORDS               8
`define SHADOW_WORDS           7
`define DATA_MSB               23
`define CHECK_LSB              26
`define CHECK_MSB              31
`define KEY_LSB                8
`define KEY_MSB                15
`define UNLOCKED_BIT           0

// reset values of the data bits
`define RST_PWM_FAULT_ENABLE   24'h000000
`define RST_QUAD_OUTPUT_CTRL   24'h081024
`define RST_FAULT_FLAG_MASK    24'h000000
`define RST_PWM_INTERFACE_CTRL 24'h670100
`define RST_OTHER              24'h000000

// pwm interface control fields
`define PWM_ENABLE_BIT         23
`define PWM_ERR_OUTPUT_EN_BIT  13
`define PWM_ERR_SELECT_BIT     12

// fault vector, bit n of the enable word
`define FAULT_COUNT            13
`define FAULT_MSB              12

// duty in 1/160 of a period: base + step * fault bit
`define PWM_PERIOD             8'd160
`define DUTY_BASE              8'd8
`define DUTY_STEP              8'd9
`define PWM_TICK_DIV           4'd4

// unlock key codes, in order
`define KEY_CODE_1             8'h00
`define KEY_CODE_2             8'h27
`define KEY_CODE_3             8'h81
`define KEY_CODE_4             8'h1f
`define KEY_CODE_5             8'h77

// interrupt status bits
`define IRQ_BITS               3
`define IRQ_UNLOCKED           0
`define IRQ_WRITE_REFUSED      1
`define IRQ_FAULT_DUTY         2

// bus answers
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10
`define RESP_DECERR            2'b11

`endif

/* File: shared/nv_config_pkg.sv */
// types shared by the configuration word block
// assumes nv_config_defines.svh for the figures
package nv_config_pkg;

	typedef enum logic [2:0] {
		KEY_IDLE  = 3'b000,
		KEY_GOT_1 = 3'b001,
		KEY_GOT_2 = 3'b010,
		KEY_GOT_3 = 3'b011,
		KEY_GOT_4 = 3'b100
	} key_state_t;

	typedef logic [23:0] cfg_data_t;
	typedef logic [5:0]  check_code_t;

endpackage

/* File: logic/nv_config_pwm_error_map.sv */
// configuration words with shadow copies, unlock key, pwm fault duty override
// assumes an axi4-lite master on REF_CLK and fault levels from other clock domains
//
// Function
// (RULE1) words always readable; writes refused unless device unlocked
// (RULE2) each enable bit lets its fault force pwm duty when both error bits set
// (RULE3) bit 12 turns overflow forces 72.5 percent duty
// (RULE4) bit 11 temperature range fault forces 66.875 percent duty
// (RULE5) bit 10 field high fault forces 61.25 percent duty
// (RULE6) bit 9 clip fault forces 55.625 percent duty
// (RULE7) bit 8 correctable memory error forces 50 percent duty
// (RULE8) bit 7 field low fault forces 44.375 percent duty
// (RULE9) bit 6 undervoltage fault forces 38.75 percent duty
// (RULE10) bit 5 averaging fault forces 33.125 percent duty
// (RULE11) bit 4 zero crossing fault forces 27.5 percent duty
// (RULE12) bit 3 loop unlock fault forces 21.875 percent duty
// (RULE13) bit 2 self-test failure forces 16.25 percent duty
// (RULE14) bit 1 uncorrectable memory error forces 10.625 percent duty
// (RULE15) bit 0 oscillator fault forces 5 percent duty
// (RULE16) host unlocks by five key writes 00 27 81 1f 77; flag reports it
// (RULE17) each word but user space has a shadow; check code in upper bits
// (RULE18) several active faults: highest enabled fault bit sets the duty
`include "nv_config_defines.svh"
`timescale 1ns/1ns

module nv_config_pwm_error_map (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST_B,
	// axi4-lite write address
	input  wire logic [11:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	// axi4-lite write data
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	// axi4-lite read address
	input  wire logic [11:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	// axi4-lite read data
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// fault levels, bit n matches enable bit n
	input  wire logic [12:0] FAULT_IN,
	// duty used when no fault overrides, in 1/160 of a period
	input  wire logic [7:0]  NORMAL_DUTY,
	// outputs
	output logic             PWM_OUT,
	output logic             IRQ
);

	////////////////////////////////////////////////////////////////////////
	// storage

	logic [31:0]                 nv_reg [`NV_WORDS];
	logic [31:0]                 shadow_reg [`SHADOW_WORDS];
	logic                        unlocked_reg;
	nv_config_pkg::key_state_t   key_state_reg;
	logic [`IRQ_BITS-1:0]        irq_status_reg;
	logic [`IRQ_BITS-1:0]        irq_mask_reg;

	// check code: parity of each nibble of the data bits
	function automatic nv_config_pkg::check_code_t check_code(input nv_config_pkg::cfg_data_t d);
		check_code = {^d[23:20], ^d[19:16], ^d[15:12], ^d[11:8], ^d[7:4], ^d[3:0]};
	endfunction

	function automatic logic [31:0] make_word(input nv_config_pkg::cfg_data_t d);
		make_word = {check_code(d), 2'b00, d};
	endfunction

	function automatic nv_config_pkg::cfg_data_t reset_data(input logic [7:0] idx);
		case (idx)
			`IDX_PWM_FAULT_ENABLE:   reset_data = `RST_PWM_FAULT_ENABLE;
			`IDX_QUAD_OUTPUT_CTRL:   reset_data = `RST_QUAD_OUTPUT_CTRL;
			`IDX_FAULT_FLAG_MASK:    reset_data = `RST_FAULT_FLAG_MASK;
			`IDX_PWM_INTERFACE_CTRL: reset_data = `RST_PWM_INTERFACE_CTRL;
			default:                 reset_data = `RST_OTHER;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// fault synchroniser

	logic [12:0] fault_meta_reg;
	logic [12:0] fault_sync_reg;

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			fault_meta_reg <= 13'h0000;
			fault_sync_reg <= 13'h0000;
		end else begin
			fault_meta_reg <= FAULT_IN;
			fault_sync_reg <= fault_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi write channel

	logic        aw_held_reg;
	logic [11:0] aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_go;
	logic [7:0]  wr_idx;
	logic [31:0] wr_mask;
	logic        wr_nv;
	logic        wr_shadow;
	logic        wr_key;
	logic        wr_refused;

	assign wr_go   = aw_held_reg && w_held_reg && !S_AXI_BVALID;
	assign wr_idx  = aw_addr_reg[9:2];
	assign wr_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	assign wr_nv     = (wr_idx >= `IDX_NV_FIRST) && (wr_idx <= `IDX_NV_LAST);
	assign wr_shadow = (wr_idx >= `IDX_SHADOW_FIRST) && (wr_idx <= `IDX_SHADOW_LAST);
	assign wr_key    = (wr_idx == `IDX_UNLOCK_KEY);
	assign wr_refused = wr_go && (wr_nv || wr_shadow) && !unlocked_reg; // RULE1

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			aw_held_reg   <= 1'b0;
			aw_addr_reg   <= 12'h000;
			S_AXI_AWREADY <= 1'b1;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_held_reg   <= 1'b1;
			aw_addr_reg   <= S_AXI_AWADDR;
			S_AXI_AWREADY <= 1'b0;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			aw_held_reg   <= 1'b0;
			S_AXI_AWREADY <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			w_held_reg   <= 1'b0;
			w_data_reg   <= 32'h00000000;
			w_strb_reg   <= 4'h0;
			S_AXI_WREADY <= 1'b1;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_held_reg   <= 1'b1;
			w_data_reg   <= S_AXI_WDATA;
			w_strb_reg   <= S_AXI_WSTRB;
			S_AXI_WREADY <= 1'b0;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			w_held_reg   <= 1'b0;
			S_AXI_WREADY <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `RESP_OKAY;
		end else if (wr_go) begin
			S_AXI_BVALID <= 1'b1;
			if (wr_refused)
				S_AXI_BRESP <= `RESP_SLVERR;
			else if (wr_nv || wr_shadow || wr_key || wr_idx == `IDX_IRQ_STATUS || wr_idx == `IDX_IRQ_MASK)
				S_AXI_BRESP <= `RESP_OKAY;
			else
				S_AXI_BRESP <= `RESP_DECERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration words and shadows

	nv_config_pkg::cfg_data_t nv_merged;
	nv_config_pkg::cfg_data_t shadow_merged;

	// only the data lanes are merged; the check code is rebuilt from them
	assign nv_merged     = (nv_reg[3'(wr_idx)][`DATA_MSB:0] & ~wr_mask[`DATA_MSB:0])
		| (w_data_reg[`DATA_MSB:0] & wr_mask[`DATA_MSB:0]);
	assign shadow_merged = (shadow_reg[3'(wr_idx)][`DATA_MSB:0] & ~wr_mask[`DATA_MSB:0])
		| (w_data_reg[`DATA_MSB:0] & wr_mask[`DATA_MSB:0]);

	// check bits are computed, written check bits are dropped
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < `NV_WORDS; i++)
				nv_reg[i] <= make_word(reset_data(`IDX_NV_FIRST + 8'(i)));
		end else if (wr_go && wr_nv && unlocked_reg) begin // RULE1
			nv_reg[3'(wr_idx)] <= make_word(nv_merged); // RULE17
		end
	end

	// user space has no shadow: shadow range stops one word short
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < `SHADOW_WORDS; i++)
				shadow_reg[i] <= make_word(reset_data(`IDX_NV_FIRST + 8'(i)));
		end else if (wr_go && wr_shadow && unlocked_reg) begin // RULE1
			shadow_reg[3'(wr_idx)] <= make_word(shadow_merged); // RULE17
		end
	end

	////////////////////////////////////////////////////////////////////////
	// unlock key sequence

	logic [7:0] key_byte;
	logic       key_write;
	logic       key_match;
	logic       unlock_event;
	nv_config_pkg::key_state_t key_restart;

	assign key_byte  = w_data_reg[`KEY_MSB:`KEY_LSB];
	assign key_restart = (key_byte == `KEY_CODE_1) ? nv_config_pkg::KEY_GOT_1 : nv_config_pkg::KEY_IDLE;
	assign key_write = wr_go && wr_key && w_strb_reg[1];

	always_comb begin
		case (key_state_reg)
			nv_config_pkg::KEY_IDLE:  key_match = (key_byte == `KEY_CODE_1);
			nv_config_pkg::KEY_GOT_1: key_match = (key_byte == `KEY_CODE_2);
			nv_config_pkg::KEY_GOT_2: key_match = (key_byte == `KEY_CODE_3);
			nv_config_pkg::KEY_GOT_3: key_match = (key_byte == `KEY_CODE_4);
			nv_config_pkg::KEY_GOT_4: key_match = (key_byte == `KEY_CODE_5);
			default:                  key_match = 1'b0;
		endcase
	end

	assign unlock_event = key_write && key_match && (key_state_reg == nv_config_pkg::KEY_GOT_4);

	// a wrong code restarts the sequence; a first code may begin it again at once
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			key_state_reg <= nv_config_pkg::KEY_IDLE;
		end else if (key_write) begin // RULE16
			case (key_state_reg)
				nv_config_pkg::KEY_IDLE:  key_state_reg <= key_match ? nv_config_pkg::KEY_GOT_1 : nv_config_pkg::KEY_IDLE;
				nv_config_pkg::KEY_GOT_1: key_state_reg <= key_match ? nv_config_pkg::KEY_GOT_2 : key_restart;
				nv_config_pkg::KEY_GOT_2: key_state_reg <= key_match ? nv_config_pkg::KEY_GOT_3 : key_restart;
				nv_config_pkg::KEY_GOT_3: key_state_reg <= key_match ? nv_config_pkg::KEY_GOT_4 : key_restart;
				nv_config_pkg::KEY_GOT_4: key_state_reg <= key_match ? nv_config_pkg::KEY_IDLE : key_restart;
				default:                  key_state_reg <= nv_config_pkg::KEY_IDLE;
			endcase
		end
	end

	// any key write that does not complete the sequence locks again
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			unlocked_reg <= 1'b0;
		else if (key_write)
			unlocked_reg <= unlock_event; // RULE16
	end

	////////////////////////////////////////////////////////////////////////
	// pwm fault override

	logic [31:0] pwm_enable_word;
	logic [31:0] pwm_iface_word;
	logic [12:0] fault_active;
	logic        override_on;
	logic [7:0]  fault_duty;
	logic        fault_hit;

	assign pwm_enable_word = shadow_reg[3'(`IDX_PWM_FAULT_ENABLE)];
	assign pwm_iface_word  = shadow_reg[3'(`IDX_PWM_INTERFACE_CTRL)];
	assign fault_active    = fault_sync_reg & pwm_enable_word[`FAULT_MSB:0]; // RULE2
	assign override_on     = pwm_iface_word[`PWM_ERR_OUTPUT_EN_BIT] && pwm_iface_word[`PWM_ERR_SELECT_BIT]; // RULE2

	// duty for bit n is base + step * n: 5 % at bit 0 up to 72.5 % at bit 12
	always_comb begin
		fault_duty = `DUTY_BASE;
		fault_hit  = 1'b0;
		for (int n = 0; n < `FAULT_COUNT; n++) begin
			if (fault_active[n]) begin // RULE18
				fault_duty = 8'(`DUTY_BASE + `DUTY_STEP * n); // RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11 RULE12 RULE13 RULE14 RULE15
				fault_hit  = 1'b1;
			end
		end
	end

	logic [3:0] tick_div_reg;
	logic       tick;
	logic [7:0] phase_reg;
	logic [7:0] duty_reg;
	logic       fault_duty_reg;

	assign tick = (tick_div_reg == `PWM_TICK_DIV - 4'd1);

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			tick_div_reg <= 4'h0;
		else
			tick_div_reg <= tick ? 4'h0 : tick_div_reg + 4'd1;
	end

	// duty is only taken at period start so a period is never cut short
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			phase_reg      <= 8'h00;
			duty_reg       <= 8'h00;
			fault_duty_reg <= 1'b0;
		end else if (tick) begin
			if (phase_reg == `PWM_PERIOD - 8'd1) begin
				phase_reg      <= 8'h00;
				fault_duty_reg <= override_on && fault_hit;
				duty_reg       <= (override_on && fault_hit) ? fault_duty : NORMAL_DUTY; // RULE2
			end else begin
				phase_reg <= phase_reg + 8'd1;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			PWM_OUT <= 1'b0;
		else
			PWM_OUT <= pwm_iface_word[`PWM_ENABLE_BIT] && (phase_reg < duty_reg);
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts

	logic fault_duty_prev_reg;
	logic [`IRQ_BITS-1:0] irq_set;
	logic [`IRQ_BITS-1:0] irq_clr;

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			fault_duty_prev_reg <= 1'b0;
		else
			fault_duty_prev_reg <= fault_duty_reg;
	end

	always_comb begin
		irq_set = '0;
		irq_set[`IRQ_UNLOCKED]      = unlock_event;
		irq_set[`IRQ_WRITE_REFUSED] = wr_refused;
		irq_set[`IRQ_FAULT_DUTY]    = fault_duty_reg && !fault_duty_prev_reg;
		irq_clr = (wr_go && wr_idx == `IDX_IRQ_STATUS && w_strb_reg[0]) ? w_data_reg[`IRQ_BITS-1:0] : '0;
	end

	// set beats a clear in the same cycle
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			irq_status_reg <= '0;
		else
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			irq_mask_reg <= '0;
		else if (wr_go && wr_idx == `IDX_IRQ_MASK && w_strb_reg[0])
			irq_mask_reg <= w_data_reg[`IRQ_BITS-1:0];
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			IRQ <= 1'b0;
		else
			IRQ <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_mask_reg);
	end

	////////////////////////////////////////////////////////////////////////
	// axi read channel

	logic [7:0]  rd_idx;
	logic [31:0] rd_word;
	logic [1:0]  rd_resp;

	assign rd_idx = S_AXI_ARADDR[9:2];

	// reads need no unlock
	always_comb begin
		rd_word = 32'h00000000;
		rd_resp = `RESP_OKAY;
		if (S_AXI_ARADDR[11:10] != 2'b00)
			rd_resp = `RESP_DECERR;
		else if (rd_idx >= `IDX_NV_FIRST && rd_idx <= `IDX_NV_LAST)
			rd_word = nv_reg[3'(rd_idx)]; // RULE1
		else if (rd_idx >= `IDX_SHADOW_FIRST && rd_idx <= `IDX_SHADOW_LAST)
			rd_word = shadow_reg[3'(rd_idx)]; // RULE1
		else if (rd_idx == `IDX_UNLOCK_KEY)
			rd_word[`UNLOCKED_BIT] = unlocked_reg; // RULE16
		else if (rd_idx == `IDX_IRQ_STATUS)
			rd_word[`IRQ_BITS-1:0] = irq_status_reg;
		else if (rd_idx == `IDX_IRQ_MASK)
			rd_word[`IRQ_BITS-1:0] = irq_mask_reg;
		else if (rd_idx == `IDX_FAULT_LIVE)
			rd_word = {18'h00000, fault_duty_reg, fault_sync_reg};
		else
			rd_resp = `RESP_DECERR;
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h00000000;
			S_AXI_RRESP   <= `RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b1;
			S_AXI_RDATA   <= rd_word;
			S_AXI_RRESP   <= rd_resp;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
		end
	end

endmodule

/* File: testbench/nv_config_chk.sv */
// assertions on bus handshakes, the read map and the pwm line
// assumes a bind onto the top of the config word block
`include "nv_config_defines.svh"
`timescale 1ns/1ns

module nv_config_chk (
	// clock and reset
	input wire logic        REF_CLK,
	input wire logic        RST_B,
	// bus
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0]  S_AXI_RRESP,
	input wire logic        S_AXI_RVALID,
	// outputs
	input wire logic        PWM_OUT,
	input wire logic        IRQ
);
	logic [9:0] hi_cnt_reg;
	logic       ar_take;
	logic [7:0] ar_idx;

	assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[11:10] == 2'b00;
	assign ar_idx  = S_AXI_ARADDR[9:2];

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			hi_cnt_reg <= 10'h000;
		else
			hi_cnt_reg <= PWM_OUT ? hi_cnt_reg + 10'h001 : 10'h000;
	end

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);

	wr_answer_a: assert property (
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
		else $error("write got no response");
	wr_busy_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while response pending");
	rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read answer late");
	rd_no_lock_a: assert property (S_AXI_RVALID |-> S_AXI_RRESP != `RESP_SLVERR)
		else $error("read refused");
	rd_map_a: assert property (
		ar_take && ar_idx inside {[8'h18:8'h1f], [8'h58:8'h5e]} |=> S_AXI_RRESP == `RESP_OKAY)
		else $error("config word read not okay");
	no_shadow_a: assert property (
		ar_take && ar_idx == 8'h5f |=> S_AXI_RRESP == `RESP_DECERR && S_AXI_RDATA == 32'h0)
		else $error("user space has a shadow");
	pwm_run_a: assert property (hi_cnt_reg <= 10'd640)
		else $error("pwm high beyond a period");
	irq_clear_a: assert property (
		$fell(IRQ) |-> S_AXI_BVALID && !$past(S_AXI_BVALID))
		else $error("irq fell without a write");

	refused_c: cover property (S_AXI_BVALID && S_AXI_BRESP == `RESP_SLVERR);
	decerr_c: cover property (S_AXI_RVALID && S_AXI_RRESP == `RESP_DECERR);
	irq_c: cover property ($rose(IRQ));
endmodule

/* File: testbench/pwm_meter.sv */
// controller side pwm reader: high time of the last pulse, in ticks
// assumes four clocks a tick and a pulse starting each period
`timescale 1ns/1ns

module pwm_meter (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// pwm line and reading
	input  wire logic       pwm,
	output logic      [7:0] duty
);
	logic [9:0] hi_cnt_reg;
	logic       pwm_reg;

	// moves only on a rising edge: a line stuck low keeps the old reading
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_cnt_reg <= 10'h000;
			pwm_reg    <= 1'b0;
			duty       <= 8'h00;
		end else begin
			pwm_reg <= pwm;
			if (pwm && !pwm_reg) begin
				duty       <= hi_cnt_reg[9:2];
				hi_cnt_reg <= 10'h001;
			end else if (pwm) begin
				hi_cnt_reg <= hi_cnt_reg + 10'h001;
			end
		end
	end
endmodule

/* File: testbench/tb_top.sv */
// top bench: bus tasks, unlock, word readback, fault duty override
// assumes pwm_meter as the controller and nv_config_chk bound below
`include "nv_config_defines.svh"
`timescale 1ns/1ns

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end

module tb_top;
	logic        ref_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic [11:0] awaddr  = 12'h000;
	logic [11:0] araddr  = 12'h000;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        arvalid = 1'b0;
	logic        bready  = 1'b1;
	logic        rready  = 1'b1;
	logic [12:0] fault   = 13'h0;
	logic [7:0]  ndut    = 8'h40;
	logic        awready;
	logic        wready;
	logic        bvalid;
	logic        arready;
	logic        rvalid;
	logic        pwm;
	logic        irq;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [31:0] rdata;
	logic [7:0]  duty;
	int          checks      = 0;
	int          miscompares = 0;
	logic [23:0] tab [8]     = '{24'h0, 24'h081024, 24'h0, 24'h670100, 24'h0, 24'h0, 24'h0, 24'h0};
	logic [7:0]  keys [5]    = '{8'h00, 8'h27, 8'h81, 8'h1f, 8'h77};

	always #2 ref_clk = ~ref_clk;

	nv_config_pwm_error_map dut_u (
		.REF_CLK(ref_clk), .RST_B(rst_b),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.FAULT_IN(fault), .NORMAL_DUTY(ndut), .PWM_OUT(pwm), .IRQ(irq)
	);

	pwm_meter meter_u (.clk(ref_clk), .rst_b(rst_b), .pwm(pwm), .duty(duty));

	//////////////////////////////////////////////////////////////
	function automatic logic [31:0] word(input logic [23:0] d);
		word = {^d[23:20], ^d[19:16], ^d[15:12], ^d[11:8], ^d[7:4], ^d[3:0], 2'b00, d};
	endfunction

	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		bit aw;
		bit w;
		aw = 1'b0;
		w  = 1'b0;
		awaddr  <= {2'b00, idx, 2'b00};
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		while (!(aw && w)) begin
			@(posedge ref_clk);
			if (!aw && awready) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (!bvalid);
		`CHK("bresp", er, bresp)
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
		araddr  <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		do @(posedge ref_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (!rvalid);
		`CHK("rresp", er, rresp)
		`CHK("rdata", e, rdata)
	endtask

	// full period for the fault to land, one to latch, one to read
	task automatic meas(input logic [7:0] e);
		repeat (2200) @(posedge ref_clk);
		`CHK("duty", e, duty)
	endtask

	task automatic unlock(input int n);
		for (int i = 0; i < n; i++)
			wr(8'h3c, {16'h0, keys[i], 8'h00}, 4'h2, 2'b00);
	endtask

	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] q;
		q = $urandom(32'hf2306e22);
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			rchk(8'(8'h18 + i), word(tab[i]), 2'b00);
			if (i < 7)
				rchk(8'(8'h58 + i), word(tab[i]), 2'b00);
		end
		rchk(8'h5f, 32'h0, 2'b11);
		rchk(8'h3c, 32'h0, 2'b00);
		wr(8'h41, 32'h7, 4'h1, 2'b00);
		wr(8'h30, 32'h1, 4'hf, 2'b11);
		wr(8'h18, 32'h1fff, 4'hf, 2'b10);
		rchk(8'h18, word(24'h0), 2'b00);
		repeat (2) @(posedge ref_clk);
		`CHK("irq", 1'b1, irq)
		rchk(8'h40, 32'h2, 2'b00);
		wr(8'h40, 32'h2, 4'h1, 2'b00);
		repeat (2) @(posedge ref_clk);
		`CHK("irq", 1'b0, irq)
		unlock(3);
		rchk(8'h3c, 32'h0, 2'b00);
		unlock(5);
		rchk(8'h3c, 32'h1, 2'b00);
		rchk(8'h40, 32'h1, 2'b00);
		// upper byte random: it must be dropped and the check code rebuilt
		for (int i = 0; i < 15; i++) begin
			q = $urandom;
			wr(8'(i < 8 ? 8'h18 + i : 8'h50 + i), q, 4'hf, 2'b00);
			rchk(8'(i < 8 ? 8'h18 + i : 8'h50 + i), word(q[23:0]), 2'b00);
		end
		ndut <= 8'($urandom_range(150, 1));
		wr(8'h5b, 32'h800000, 4'hf, 2'b00);
		wr(8'h58, 32'h1fff, 4'hf, 2'b00);
		fault <= 13'h1fff;
		meas(ndut);
		wr(8'h5b, 32'h803000, 4'hf, 2'b00);
		for (int n = 0; n < 13; n++) begin
			fault <= (13'h1 << n) | (13'($urandom) & ((13'h1 << n) - 13'h1));
			meas(8'd8 + 8'd9 * 8'(n));
		end
		rchk(8'h42, {18'h0, 1'b1, fault}, 2'b00);
		fault <= 13'h1000;
		wr(8'h58, 32'h0fff, 4'hf, 2'b00);
		meas(ndut);
		wr(8'h58, 32'h1fff, 4'hf, 2'b00);
		wr(8'h5b, 32'h802000, 4'hf, 2'b00);
		meas(ndut);
		wrap_up;
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		miscompares++;
		wrap_up;
	end
endmodule

bind nv_config_pwm_error_map nv_config_chk chk_u (
	.REF_CLK(REF_CLK), .RST_B(RST_B),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
	.PWM_OUT(PWM_OUT), .IRQ(IRQ)
);
